/* design/cmd_parser_defines.svh */
// constants for the setup-mode string command parser
// assumes a 125 MHz clock and byte-wide host and radio streams
`ifndef CMD_PARSER_DEFINES_SVH
`define CMD_PARSER_DEFINES_SVH
`define CH_OPEN_BRACKET 8'h5B
`define CH_CLOSE_BRACKET 8'h5D
`define CH_CR 8'h0D
`define CH_DOLLAR 8'h24
`define CH_COLON 8'h3A
`define AUX_MAX_LEN 30
`define TX_MAX_LEN 16
`define CLK_MHZ 125
`define INIT_DELAY_MS 20
`define PREAMBLE_MS 50
`define BURST_MS 40
`define ACK_BURST_MS 20
`define MS_CYCLES(ms) ((ms) * 1000 * `CLK_MHZ)
`endif

/* design/cmd_parser_pkg.sv */
// types for the setup-mode string command parser
// assumes the defines header is included by the design files
package cmd_parser_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_AUX,
    ST_LEN,
    ST_DATA,
    ST_DELAY,
    ST_PREAMBLE,
    ST_SEND,
    ST_ACK
  } parse_state_e;
endpackage

/* design/tx_buffer_mem.sv */
// small transient buffer holding one radio packet payload
// assumes a single writer and single reader on one clock
`timescale 1ns/100ps
module tx_buffer_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk, // clock
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [7:0] wr_data, // write byte
  input wire logic [AW-1:0] rd_addr, // read address
  output logic [7:0] rd_data // registered read byte
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* design/modem_string_command_parser.sv */
// What this block does
// - in setup mode an open bracket starts and a close bracket ends a string copied out on the aux stream.
// - an aux string holds zero to thirty bytes; extra bytes beyond thirty are dropped.
// - an aux string ended by carriage return is sent out followed by a carriage return byte.
// - a dollar in setup mode starts a one-packet radio transmit, then parsing returns to setup mode.
// - the byte after the dollar is one hex digit and the buffer length is that value plus one.
// - right after the length digit is taken a colon is echoed to the host.
// - once the last data byte has arrived and the initial delay has run out, the radio is keyed and the packet sent.
// - byte intake is never stalled so a 4800 baud stream cannot overflow.
// - default single-byte latency is initial delay plus preamble plus about 40 ms of burst.
// - in acknowledge mode the acknowledge burst occupies about 20 ms.
// - the initial delay runs from the first buffered byte until the transmitter keys up.
// assumes host bytes arrive as single-cycle strobes and the aux and echo sinks always accept
`timescale 1ns/100ps
`include "cmd_parser_defines.svh"
module modem_string_command_parser #(
  parameter int DELAY_CYCLES = `MS_CYCLES(`INIT_DELAY_MS),
  parameter int PREAMBLE_CYCLES = `MS_CYCLES(`PREAMBLE_MS),
  parameter int BURST_CYCLES = `MS_CYCLES(`BURST_MS),
  parameter int ACK_CYCLES = `MS_CYCLES(`ACK_BURST_MS)
) (
  input wire logic clk, // 125 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic setup_mode, // parser active when high
  input wire logic ack_mode, // acknowledge mode enabled
  input wire logic rx_valid, // host byte strobe
  input wire logic [7:0] rx_data, // host byte
  output logic echo_valid, // echo byte strobe to host
  output logic [7:0] echo_data, // echo byte
  output logic aux_valid, // aux byte strobe
  output logic [7:0] aux_data, // aux byte
  output logic radio_key, // transmitter keyed
  output logic radio_valid, // payload byte strobe to radio
  output logic [7:0] radio_data, // payload byte
  output logic busy // transmit command in progress
);
  cmd_parser_pkg::parse_state_e state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [4:0] len_r, len_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic echo_valid_nxt, aux_valid_nxt, key_nxt, rv_nxt, busy_nxt;
  logic [7:0] echo_data_nxt, aux_data_nxt;
  logic rv_pend_r, rv_pend_nxt;
  logic [7:0] radio_data_nxt;
  logic is_hex;
  logic [3:0] hex_val;
  logic wr_en;
  logic [3:0] rd_addr;
  logic [7:0] rd_byte;

  always_comb begin
    is_hex = 1'b1;
    hex_val = 4'h0;
    if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
      hex_val = rx_data[3:0];
    end else if ((rx_data >= 8'h41 && rx_data <= 8'h46) || (rx_data >= 8'h61 && rx_data <= 8'h66)) begin
      hex_val = rx_data[3:0] + 4'h9;
    end else begin
      is_hex = 1'b0;
    end
  end

  assign wr_en = (state_r == cmd_parser_pkg::ST_DATA) && rx_valid;
  assign rd_addr = cnt_r[3:0];

  tx_buffer_mem #(.DEPTH(`TX_MAX_LEN), .AW(4)) u_buf (
    .clk(clk),
    .wr_en(wr_en),
    .wr_addr(cnt_r[3:0]),
    .wr_data(rx_data),
    .rd_addr(rd_addr),
    .rd_data(rd_byte)
  );

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    tmr_nxt = tmr_r;
    echo_valid_nxt = 1'b0;
    echo_data_nxt = echo_data;
    aux_valid_nxt = 1'b0;
    aux_data_nxt = aux_data;
    key_nxt = radio_key;
    rv_nxt = 1'b0;
    rv_pend_nxt = 1'b0;
    busy_nxt = busy;
    radio_data_nxt = radio_data;
    unique case (state_r)
      cmd_parser_pkg::ST_IDLE: begin
        if (rx_valid && setup_mode) begin
          if (rx_data == `CH_OPEN_BRACKET) begin
            state_nxt = cmd_parser_pkg::ST_AUX;
            cnt_nxt = 5'd0;
          end else if (rx_data == `CH_DOLLAR) begin
            state_nxt = cmd_parser_pkg::ST_LEN;
            busy_nxt = 1'b1;
          end
        end
      end
      cmd_parser_pkg::ST_AUX: begin
        if (rx_valid) begin
          if (rx_data == `CH_CLOSE_BRACKET) begin
            state_nxt = cmd_parser_pkg::ST_IDLE;
          end else if (rx_data == `CH_CR) begin
            aux_valid_nxt = 1'b1;
            aux_data_nxt = `CH_CR;
            state_nxt = cmd_parser_pkg::ST_IDLE;
          end else if (cnt_r < 5'(`AUX_MAX_LEN)) begin
            aux_valid_nxt = 1'b1;
            aux_data_nxt = rx_data;
            cnt_nxt = cnt_r + 5'd1;
          end
        end
      end
      cmd_parser_pkg::ST_LEN: begin
        if (rx_valid) begin
          if (is_hex) begin
            len_nxt = {1'b0, hex_val} + 5'd1;
            cnt_nxt = 5'd0;
            tmr_nxt = 32'd0;
            echo_valid_nxt = 1'b1;
            echo_data_nxt = `CH_COLON;
            state_nxt = cmd_parser_pkg::ST_DATA;
          end else begin
            // a non-hex length aborts the command rather than guessing a size
            state_nxt = cmd_parser_pkg::ST_IDLE;
            busy_nxt = 1'b0;
          end
        end
      end
      cmd_parser_pkg::ST_DATA: begin
        // the initial delay is timed from the first byte into the empty buffer, not the last
        if (cnt_r != 5'd0) begin
          tmr_nxt = tmr_r + 32'd1;
        end
        if (rx_valid) begin
          cnt_nxt = cnt_r + 5'd1;
          if (cnt_r + 5'd1 == len_r) begin
            state_nxt = cmd_parser_pkg::ST_DELAY;
          end
        end
      end
      cmd_parser_pkg::ST_DELAY: begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmr_r + 32'd1 >= 32'(DELAY_CYCLES)) begin
          key_nxt = 1'b1;
          tmr_nxt = 32'd0;
          state_nxt = cmd_parser_pkg::ST_PREAMBLE;
        end
      end
      cmd_parser_pkg::ST_PREAMBLE: begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmr_r + 32'd1 >= 32'(PREAMBLE_CYCLES)) begin
          tmr_nxt = 32'd0;
          cnt_nxt = 5'd0;
          state_nxt = cmd_parser_pkg::ST_SEND;
        end
      end
      cmd_parser_pkg::ST_SEND: begin
        // payload read is registered and so is the strobe, so radio strobes lag the address by two cycles
        tmr_nxt = tmr_r + 32'd1;
        if (cnt_r < len_r) begin
          rv_pend_nxt = 1'b1;
          cnt_nxt = cnt_r + 5'd1;
        end
        rv_nxt = rv_pend_r;
        // byte is latched beside its strobe so the pair leaves in the same cycle
        if (rv_pend_r) begin
          radio_data_nxt = rd_byte;
        end
        if (tmr_r + 32'd1 >= 32'(BURST_CYCLES)) begin
          tmr_nxt = 32'd0;
          key_nxt = ack_mode;
          state_nxt = ack_mode ? cmd_parser_pkg::ST_ACK : cmd_parser_pkg::ST_IDLE;
          busy_nxt = ack_mode;
        end
      end
      cmd_parser_pkg::ST_ACK: begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmr_r + 32'd1 >= 32'(ACK_CYCLES)) begin
          key_nxt = 1'b0;
          busy_nxt = 1'b0;
          state_nxt = cmd_parser_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // host bytes are consumed every cycle they arrive, so intake never backs up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= cmd_parser_pkg::ST_IDLE;
      cnt_r <= 5'd0;
      len_r <= 5'd0;
      tmr_r <= 32'd0;
      echo_valid <= 1'b0;
      echo_data <= 8'h00;
      aux_valid <= 1'b0;
      aux_data <= 8'h00;
      radio_key <= 1'b0;
      radio_valid <= 1'b0;
      rv_pend_r <= 1'b0;
      busy <= 1'b0;
      radio_data <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      tmr_r <= tmr_nxt;
      echo_valid <= echo_valid_nxt;
      echo_data <= echo_data_nxt;
      aux_valid <= aux_valid_nxt;
      aux_data <= aux_data_nxt;
      radio_key <= key_nxt;
      radio_valid <= rv_nxt;
      rv_pend_r <= rv_pend_nxt;
      busy <= busy_nxt;
      radio_data <= radio_data_nxt;
    end
  end
endmodule

/* verification/parser_monitor.sv */
// port assertions for the string command parser
// assumes ack_mode holds steady while the transmitter is keyed
`timescale 1ns/100ps
module parser_monitor #(
  parameter int PREAMBLE_CYCLES = 20,
  parameter int BURST_CYCLES = 40,
  parameter int ACK_CYCLES = 10
) (
  input wire logic clk, // clock
  input wire logic resetn, // async reset, active low
  input wire logic ack_mode, // acknowledge mode
  input wire logic rx_valid, // host byte strobe
  input wire logic echo_valid, // echo strobe
  input wire logic [7:0] echo_data, // echo byte
  input wire logic aux_valid, // aux strobe
  input wire logic radio_key, // transmitter keyed
  input wire logic radio_valid, // payload strobe
  input wire logic busy // command in progress
);
  int key_cnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) key_cnt_r <= 0;
    else key_cnt_r <= radio_key ? key_cnt_r + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ECHO_COLON: assert property (echo_valid |-> echo_data == 8'h3A)
    else $error("echo byte is not a colon");
  AST_AUX_AFTER_BYTE: assert property (aux_valid |-> $past(rx_valid))
    else $error("aux byte without a host byte");
  AST_KEY_WITH_BUSY: assert property (radio_key |-> busy)
    else $error("key high while idle");
  AST_PAYLOAD_IN_KEY: assert property (radio_valid |-> radio_key)
    else $error("payload sent unkeyed");
  AST_KEY_LENGTH: assert property ($fell(radio_key) |->
    key_cnt_r == PREAMBLE_CYCLES + BURST_CYCLES + (ack_mode ? ACK_CYCLES : 0))
    else $error("key hold length wrong");
  AST_PREAMBLE_QUIET: assert property ($rose(radio_key) |-> !radio_valid [*8])
    else $error("payload inside preamble");
  AST_DELAY_QUIET: assert property ($rose(busy) |-> !radio_key [*8])
    else $error("key up before delay");
  AST_BUSY_ENDS: assert property ($fell(radio_key) |-> ##[0:1] !busy)
    else $error("busy outlives key");
endmodule
bind modem_string_command_parser parser_monitor #(.PREAMBLE_CYCLES(PREAMBLE_CYCLES),
  .BURST_CYCLES(BURST_CYCLES), .ACK_CYCLES(ACK_CYCLES)) parser_monitor_inst (.clk(clk), .resetn(resetn),
  .ack_mode(ack_mode), .rx_valid(rx_valid), .echo_valid(echo_valid), .echo_data(echo_data),
  .aux_valid(aux_valid), .radio_key(radio_key), .radio_valid(radio_valid), .busy(busy));

/* verification/host_model.sv */
// host side model: plays command strings one byte per clock and counts echoes
// assumes the parser never stalls intake, so no flow control is modelled
`timescale 1ns/100ps
module host_model (
  input wire logic clk, // clock
  output logic rx_valid, // byte strobe
  output logic [7:0] rx_data, // byte
  input wire logic echo_valid, // echo strobe
  input wire logic [7:0] echo_data // echo byte
);
  int colons = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  always @(posedge clk) if (echo_valid === 1'b1 && echo_data === 8'h3A) colons++;
  // a command may carry fewer or more bytes than length plus one payload bytes; bursts stay short
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= s[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // a stale byte must not look like fresh data
  endtask
endmodule

/* verification/modem_string_command_parser_bench.sv */
// self-checking bench for the string command parser
// assumes short timing parameters so a keyed packet ends within 300 cycles
`timescale 1ns/100ps
module modem_string_command_parser_bench;
  typedef struct {string cmd; logic ack; string aux; string radio; int colons;} row_s;
  logic clk = 0, resetn = 0, setup_mode = 1, ack_mode = 0;
  logic rx_valid, echo_valid, aux_valid, radio_key, radio_valid, busy;
  logic [7:0] rx_data, echo_data, aux_data, radio_data;
  logic [7:0] aux_q[$], rad_q[$];
  int bad_count = 0, comparisons = 0, cycles = 0, c0;
  string s, e;
  row_s rows[7] = '{'{"[AB]", 0, "AB", "", 0}, '{"Z[XY\015", 0, "XY\015", "", 0}, '{"$0Q", 0, "", "Q", 1},
    '{"$a0123456789A", 1, "", "0123456789A", 1}, '{"$F0123456789ABCDEF", 0, "", "0123456789ABCDEF", 1},
    '{"$G[Q]", 0, "Q", "", 0}, '{"$0Q[R]", 1, "", "Q", 1}};
  modem_string_command_parser #(.DELAY_CYCLES(20), .PREAMBLE_CYCLES(20), .BURST_CYCLES(40), .ACK_CYCLES(10))
    modem_string_command_parser_inst (.clk(clk), .resetn(resetn), .setup_mode(setup_mode),
    .ack_mode(ack_mode), .rx_valid(rx_valid), .rx_data(rx_data), .echo_valid(echo_valid),
    .echo_data(echo_data), .aux_valid(aux_valid), .aux_data(aux_data), .radio_key(radio_key),
    .radio_valid(radio_valid), .radio_data(radio_data), .busy(busy));
  host_model host_model_inst (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .echo_valid(echo_valid),
    .echo_data(echo_data));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (aux_valid === 1'b1) aux_q.push_back(aux_data);
    if (radio_valid === 1'b1) rad_q.push_back(radio_data);
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_q(input string name, input string exp, input logic [7:0] q[$]);
    logic ok;
    ok = (q.size() == exp.len());
    foreach (q[i]) if (ok && q[i] !== exp[i]) ok = 0;
    comparisons++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH %s expected %s seen %p", name, exp, q);
    end
  endtask
  task automatic cmp_b(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cmp_n(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic run_row(input row_s r);
    ack_mode <= r.ack;
    aux_q.delete();
    rad_q.delete();
    c0 = host_model_inst.colons;
    host_model_inst.send(r.cmd); // bytes back to back
    repeat (3) @(posedge clk);
    for (int n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk);
    cmp_b("busy done", 1'b0, busy);
    repeat (2) @(posedge clk);
    cmp_q("aux", r.aux, aux_q);
    cmp_q("radio", r.radio, rad_q);
    cmp_n("colon", r.colons, host_model_inst.colons - c0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    cmp_b("busy in reset", 1'b0, busy);
    resetn <= 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    s = "[";
    e = "";
    repeat (31) s = {s, "A"};
    repeat (30) e = {e, "A"};
    run_row('{{s, "]"}, 0, e, "", 0});
    setup_mode <= 1'b0;
    run_row('{"[Q]$0Z", 0, "", "", 0});
    setup_mode <= 1'b1;
    host_model_inst.send("$3ab");
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_b("key in reset", 1'b0, radio_key);
    cmp_b("busy after abort", 1'b0, busy);
    resetn <= 1'b1;
    run_row('{"[K]", 0, "K", "", 0});
    summarize();
  end
endmodule
